// *** design/pic_irq_ctrl_unit.sv ***
`timescale 1ns/1ps
module pic_irq_ctrl_unit
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Avalon-MM register slave
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// Interrupt sources
	input wire logic wr_timeout_irq,
	input wire logic [7:0] ext_int,
	input wire logic [18:0] periph_irq,
	// Requests out
	output logic cpu_irq,
	output logic [4:0] cpu_cause,
	output logic [2:0] cpu_level,
	output logic flag_irq_out
);

	// The core timer and software interrupts have no port here.

	function automatic logic [31:0] pic_be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[8*b +: 8] = 8'hFF;
			end
		end
		return m;
	endfunction

	function automatic logic [31:0] pic_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] m;
		m = pic_be_mask(be);
		return (old_v & ~m) | (new_v & m);
	endfunction

	// True when the bus address selects the register word at ofs.
	function automatic logic pic_at(input logic [15:0] a, input logic [15:0] ofs);
		return a[15:2] == ofs[15:2];
	endfunction

	// Returns {found, number, level} of the winning request.
	function automatic logic [8:0] pic_pick(input logic [31:0] elig,
		input logic [95:0] lv);
		logic [2:0] bl;
		logic [4:0] bn;
		bl = 3'h0;
		bn = 5'h00;
		for (int i = 0; i < PIC_NUM_SOURCES; i++) begin
			// Strictly greater keeps the smaller number on a tie.
			if (elig[i] && (lv[3*i +: 3] > bl)) begin
				bl = lv[3*i +: 3];
				bn = 5'(i);
			end
		end
		return {(bl != 3'h0), bn, bl};
	endfunction

	logic detect_enable_bit;
	logic [31:0] detection_mode_reg_lo;
	logic [31:0] detection_mode_reg_hi;
	logic [2:0] level_field [PIC_NUM_SOURCES];
	logic [2:0] mask_level_reg;
	logic [31:0] irq_flag_reg;
	logic [4:0] cause_field;
	logic [2:0] current_level_field;
	logic request_flag;
	logic [31:0] pending_reg;

	logic bus_ack;
	logic bus_req;
	logic wr_fire;
	logic [31:0] rd_word;
	logic [15:0] level_ofs;
	logic [2:0] level_idx;
	logic level_hit;
	logic [31:0] wdata_be;

	logic [7:0] ext_meta;
	logic [7:0] ext_sync;
	logic [31:0] raw_src;
	logic [31:0] edge_clr;
	logic [31:0] eligible;
	logic [95:0] level_flat;
	logic [8:0] pick;
	logic pick_found;
	logic [4:0] pick_num;
	logic [2:0] pick_lvl;
	logic reselect;
	logic cur_dropped;
	logic cur_lowered;
	logic higher_seen;
	logic [15:0] word_addr;

	// Bus slave: one wait cycle, answer at the second edge of a request.
	assign bus_req = avs_read || avs_write;
	assign avs_waitrequest = bus_req && !bus_ack;
	assign wr_fire = avs_write && bus_ack;
	assign wdata_be = avs_writedata & pic_be_mask(avs_byteenable);
	assign word_addr = {avs_address[15:2], 2'b00};

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_ack <= 1'b0;
		end else begin
			bus_ack <= bus_req && !bus_ack;
		end
	end

	// Level words are decoded as a range so that one index serves all eight.
	always_comb begin
		level_ofs = avs_address - PIC_LEVEL_BASE_OFS;
		level_idx = level_ofs[4:2];
		level_hit = (avs_address[15:2] >= PIC_LEVEL_BASE_OFS[15:2]) &&
			(avs_address[15:2] <= PIC_LEVEL_LAST_OFS[15:2]);
	end

	always_comb begin
		rd_word = PIC_RST_WORD;
		if (level_hit) begin
			for (int j = 0; j < PIC_LEVELS_PER_REG; j++) begin
				rd_word[PIC_LEVEL_FIELD_STRIDE*j +: 3] =
					level_field[PIC_LEVELS_PER_REG*level_idx + j];
			end
		end else begin
			case (word_addr)
				PIC_DET_EN_OFS: rd_word[PIC_DET_EN_BIT] = detect_enable_bit;
				PIC_MODE_LO_OFS: rd_word = detection_mode_reg_lo;
				PIC_MODE_HI_OFS: rd_word = detection_mode_reg_hi;
				PIC_MASK_OFS: rd_word[PIC_MASK_LVL_LSB +: 3] = mask_level_reg;
				PIC_PENDING_OFS: rd_word = pending_reg;
				PIC_STATUS_OFS: begin
					rd_word[PIC_STAT_CAUSE_LSB +: 5] = cause_field;
					rd_word[PIC_STAT_LEVEL_LSB +: 3] = current_level_field;
					rd_word[PIC_STAT_FLAG_BIT] = request_flag;
				end
				PIC_FLAG0_OFS: rd_word = irq_flag_reg;
				PIC_FLAG1_OFS: rd_word = irq_flag_reg;
				default: rd_word = PIC_RST_WORD;
			endcase
		end
	end

	// Read data is captured in the wait cycle so that it stands at the completing edge.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= PIC_RST_WORD;
		end else if (avs_read && !bus_ack) begin
			avs_readdata <= rd_word;
		end
	end

	// Control registers.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			detect_enable_bit <= 1'b0;
			detection_mode_reg_lo <= PIC_RST_WORD;
			detection_mode_reg_hi <= PIC_RST_WORD;
			mask_level_reg <= PIC_RST_LEVEL;
		end else if (wr_fire) begin
			case (word_addr)
				PIC_DET_EN_OFS: begin
					if (avs_byteenable[0]) begin
						detect_enable_bit <= avs_writedata[PIC_DET_EN_BIT];
					end
				end
				PIC_MODE_LO_OFS: detection_mode_reg_lo <=
					pic_merge(detection_mode_reg_lo, avs_writedata, avs_byteenable);
				PIC_MODE_HI_OFS: detection_mode_reg_hi <=
					pic_merge(detection_mode_reg_hi, avs_writedata, avs_byteenable);
				PIC_MASK_OFS: begin
					if (avs_byteenable[0]) begin
						mask_level_reg <= avs_writedata[PIC_MASK_LVL_LSB +: 3];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Level registers: four sources per word, one per byte lane.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PIC_NUM_SOURCES; i++) begin
				level_field[i] <= PIC_RST_LEVEL;
			end
		end else if (wr_fire && level_hit) begin
			for (int j = 0; j < PIC_LEVELS_PER_REG; j++) begin
				if (avs_byteenable[j]) begin
					level_field[PIC_LEVELS_PER_REG*level_idx + j] <=
						avs_writedata[PIC_LEVEL_FIELD_STRIDE*j +: 3];
				end
			end
		end
	end

	// Flag register: word 0 writes both ways, word 1 only sets bits.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_reg <= PIC_RST_WORD;
		end else if (wr_fire && pic_at(avs_address, PIC_FLAG0_OFS)) begin
			irq_flag_reg <= pic_merge(irq_flag_reg, avs_writedata, avs_byteenable);
		end else if (wr_fire && pic_at(avs_address, PIC_FLAG1_OFS)) begin
			irq_flag_reg <= irq_flag_reg | wdata_be;
		end
	end

	// The outgoing flag request is registered so that it never glitches.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_irq_out <= 1'b0;
		end else begin
			flag_irq_out <= |irq_flag_reg;
		end
	end

	// External pins pass a two-flop synchroniser.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta <= 8'h00;
			ext_sync <= 8'h00;
		end else begin
			ext_meta <= ext_int;
			ext_sync <= ext_meta;
		end
	end

	// Reserved numbers stay tied low; every other number has one source.
	always_comb begin
		raw_src = PIC_RST_WORD;
		raw_src[PIC_NUM_WR_TIMEOUT] = wr_timeout_irq;
		raw_src[PIC_NUM_EXT_BASE +: PIC_NUM_EXT] = ext_sync;
		raw_src[17:11] = periph_irq[6:0];
		raw_src[PIC_NUM_FLAG] = |irq_flag_reg;
		raw_src[30:19] = periph_irq[18:7];
	end

	// Edge clear register decodes into one-cycle clear strobes.
	always_comb begin
		edge_clr = PIC_RST_WORD;
		if (wr_fire && pic_at(avs_address, PIC_EDGE_CLR_OFS)) begin
			if (wdata_be[PIC_EDGE_EN_A_BIT]) begin
				edge_clr = edge_clr | (32'h0000_0001 <<
					avs_writedata[PIC_EDGE_SRC_A_LSB +: 5]);
			end
			if (wdata_be[PIC_EDGE_EN_B_BIT]) begin
				edge_clr = edge_clr | (32'h0000_0001 <<
					avs_writedata[PIC_EDGE_SRC_B_LSB +: 5]);
			end
		end
	end

	for (genvar g = 0; g < PIC_NUM_SOURCES; g++) begin : gen_src
		logic [1:0] src_mode;
		assign src_mode = (g < 16) ? detection_mode_reg_lo[2*(g%16) +: 2] :
			detection_mode_reg_hi[2*(g%16) +: 2];
		pic_src_detect #(
			.USED(!PIC_RESERVED_MASK[g])
		) u_det (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.detect_en(detect_enable_bit),
			.mode(src_mode),
			.clear(edge_clr[g]),
			.raw(raw_src[g]),
			.pending(pending_reg[g])
		);
	end

	// A request takes part only when pending, non-zero and not below the mask.
	always_comb begin
		for (int i = 0; i < PIC_NUM_SOURCES; i++) begin
			level_flat[3*i +: 3] = level_field[i];
			eligible[i] = pending_reg[i] &&
				(level_field[i] != PIC_RST_LEVEL) &&
				(level_field[i] >= mask_level_reg);
		end
		pick = pic_pick(eligible, level_flat);
		pick_found = pick[8];
		pick_num = pick[7:3];
		pick_lvl = pick[2:0];
	end

	// Reselection triggers; an equal level with a smaller number is not one.
	always_comb begin
		cur_dropped = !eligible[cause_field];
		cur_lowered = level_field[cause_field] < current_level_field;
		higher_seen = pick_lvl > current_level_field;
		reselect = !request_flag || cur_dropped || cur_lowered || higher_seen;
	end

	// Current status: held until a reselection event.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cause_field <= PIC_RST_CAUSE;
			current_level_field <= PIC_RST_LEVEL;
			request_flag <= 1'b0;
		end else if (reselect) begin
			if (pick_found) begin
				cause_field <= pick_num;
				current_level_field <= pick_lvl;
				request_flag <= 1'b1;
			end else begin
				request_flag <= 1'b0;
			end
		end
	end

	assign cpu_irq = request_flag;
	assign cpu_cause = cause_field;
	assign cpu_level = current_level_field;

endmodule

// *** design/pic_pkg.sv ***
package pic_pkg;

	// Byte addresses of the register words on the Avalon-MM slave.
	localparam logic [15:0] PIC_DET_EN_OFS = 16'hF600;
	localparam logic [15:0] PIC_MODE_LO_OFS = 16'hF604;
	localparam logic [15:0] PIC_MODE_HI_OFS = 16'hF608;
	localparam logic [15:0] PIC_LEVEL_BASE_OFS = 16'hF610;
	localparam logic [15:0] PIC_LEVEL_LAST_OFS = 16'hF62C;
	localparam logic [15:0] PIC_MASK_OFS = 16'hF640;
	localparam logic [15:0] PIC_EDGE_CLR_OFS = 16'hF660;
	localparam logic [15:0] PIC_PENDING_OFS = 16'hF680;
	localparam logic [15:0] PIC_STATUS_OFS = 16'hF6A0;
	localparam logic [15:0] PIC_FLAG0_OFS = 16'hF6C0;
	localparam logic [15:0] PIC_FLAG1_OFS = 16'hF6C4;

	// Field positions.
	localparam int PIC_DET_EN_BIT = 0;
	localparam int PIC_MASK_LVL_LSB = 0;
	localparam int PIC_EDGE_SRC_A_LSB = 0;
	localparam int PIC_EDGE_EN_A_BIT = 7;
	localparam int PIC_EDGE_SRC_B_LSB = 16;
	localparam int PIC_EDGE_EN_B_BIT = 23;
	localparam int PIC_STAT_CAUSE_LSB = 0;
	localparam int PIC_STAT_LEVEL_LSB = 8;
	localparam int PIC_STAT_FLAG_BIT = 16;
	localparam int PIC_LEVELS_PER_REG = 4;
	localparam int PIC_LEVEL_FIELD_STRIDE = 8;

	// Reset values.
	localparam logic [31:0] PIC_RST_WORD = 32'h0000_0000;
	localparam logic [2:0] PIC_RST_LEVEL = 3'h0;
	localparam logic [4:0] PIC_RST_CAUSE = 5'h00;

	// Source numbering.
	localparam int PIC_NUM_SOURCES = 32;
	localparam int PIC_NUM_WR_TIMEOUT = 1;
	localparam int PIC_NUM_EXT_BASE = 2;
	localparam int PIC_NUM_EXT = 8;
	localparam int PIC_NUM_FLAG = 18;
	localparam logic [31:0] PIC_RESERVED_MASK = 32'h8000_0401;

	typedef enum logic [1:0] {
		PIC_MODE_LOW = 2'h0,
		PIC_MODE_HIGH = 2'h1,
		PIC_MODE_FALL = 2'h2,
		PIC_MODE_RISE = 2'h3
	} pic_mode_e;

endpackage

// *** design/pic_src_detect.sv ***
`timescale 1ns/1ps
module pic_src_detect
	import pic_pkg::*;
#(
	parameter bit USED = 1'b1
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Control
	input wire logic detect_en,
	input wire logic [1:0] mode,
	input wire logic clear,
	// Source and result
	input wire logic raw,
	output logic pending
);

	logic prev;
	logic latched;
	logic edge_hit;
	logic level_mode;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prev <= 1'b0;
		end else begin
			prev <= raw;
		end
	end

	always_comb begin
		level_mode = (mode == PIC_MODE_LOW) || (mode == PIC_MODE_HIGH);
		case (mode)
			PIC_MODE_RISE: edge_hit = raw & ~prev;
			PIC_MODE_FALL: edge_hit = ~raw & prev;
			default: edge_hit = 1'b0;
		endcase
	end

	// An edge in the same cycle as a clear keeps the request.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			latched <= 1'b0;
		end else if (!USED) begin
			latched <= 1'b0;
		end else if (detect_en && edge_hit) begin
			latched <= 1'b1;
		end else if (clear || level_mode) begin
			latched <= 1'b0;
		end
	end

	// Level modes follow the source; edge modes hold until cleared.
	assign pending = USED && detect_en &&
		(level_mode ? (raw == mode[0]) : latched);

endmodule

// *** dv/pic_asserts.sv ***
`timescale 1ns/1ps
module pic_asserts
	import pic_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Register bus
	input wire logic [15:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic avs_waitrequest,
	// Sources and requests
	input wire logic wr_timeout_irq,
	input wire logic [7:0] ext_int,
	input wire logic [18:0] periph_irq,
	input wire logic cpu_irq,
	input wire logic [4:0] cpu_cause,
	input wire logic [2:0] cpu_level,
	input wire logic flag_irq_out
);
	logic det_q;
	logic [2:0] quiet;
	logic bus_req;
	assign bus_req = avs_read || avs_write;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Tracks the detection enable bit from completed writes.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) det_q <= 1'b0;
		else if (avs_write && !avs_waitrequest && avs_address[15:2] == PIC_DET_EN_OFS[15:2])
			det_q <= avs_writedata[0];
	end
	// Counts cycles with no write and no source change.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) quiet <= 3'h0;
		else if (avs_write || $changed({wr_timeout_irq, ext_int, periph_irq})) quiet <= 3'h0;
		else if (quiet != 3'h7) quiet <= quiet + 3'h1;
	end
	AST_WAIT_FIRST: assert property ($rose(bus_req) |-> avs_waitrequest)
		else $error("wait state missing");
	AST_WAIT_ONE: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
		else $error("wait state too long");
	AST_WAIT_IDLE: assert property (!bus_req |-> !avs_waitrequest)
		else $error("wait while idle");
	AST_LVL_NZ: assert property (cpu_irq |-> cpu_level != 3'h0)
		else $error("request at level zero");
	AST_RSV: assert property (cpu_irq |-> !(cpu_cause inside {5'h00, 5'h0A, 5'h1F}))
		else $error("reserved cause");
	AST_HOLD: assert property (quiet == 3'h7 |-> $stable({cpu_irq, cpu_cause, cpu_level}))
		else $error("status changed without cause");
	AST_FLAG: assert property (quiet >= 3'h2 |-> $stable(flag_irq_out))
		else $error("flag output changed without write");
	AST_DET_OFF: assert property (!det_q && !$past(det_q) |-> !cpu_irq)
		else $error("request while detection off");
endmodule
bind pic_irq_ctrl_unit pic_asserts i_pic_asserts (.sys_clk, .rst_n, .avs_address, .avs_read,
	.avs_write, .avs_writedata, .avs_waitrequest, .wr_timeout_irq, .ext_int, .periph_irq,
	.cpu_irq, .cpu_cause, .cpu_level, .flag_irq_out);

// *** dv/pic_src_model.sv ***
`timescale 1ns/1ps
module pic_src_model (
	// Clock
	input wire logic sys_clk,
	// Source pattern from the bench
	input wire logic [27:0] src_cmd,
	// Source lines
	output logic wr_timeout_irq,
	output logic [7:0] ext_int,
	output logic [18:0] periph_irq
);
	// Core timer and software interrupts go to the core directly and are not driven here.
	initial {periph_irq, ext_int, wr_timeout_irq} = 28'h0;
	always @(posedge sys_clk) begin
		{periph_irq, ext_int, wr_timeout_irq} <= src_cmd;
	end
endmodule

// *** dv/pic_irq_ctrl_unit_tb.sv ***
`timescale 1ns/1ps
module pic_irq_ctrl_unit_tb
	import pic_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [15:0] avs_address = 16'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata, d;
	logic avs_waitrequest, wr_timeout_irq, cpu_irq, flag_irq_out;
	logic [7:0] ext_int;
	logic [18:0] periph_irq;
	logic [4:0] cpu_cause;
	logic [2:0] cpu_level;
	logic [31:0] src = 32'h0;
	int fails = 0;
	int n_checks = 0;
	logic [31:0] st;
	logic [7:0] e;
	logic [31:0] lv [8] = '{32'h0303_0503, 32'h0303_0303, 32'h0003_0303, 32'h0303_0303,
		32'h0303_0303, 32'h0303_0703, 32'h0303_0303, 32'h0301_0303};
	// Source pattern by interrupt number, then expected cause and level.
	logic [39:0] rows [7] = '{40'h0000_0800_00, 40'h4000_0000_00, 40'h0000_3000_63,
		40'h0000_1002_0D, 40'h0020_0002_AF, 40'h0000_0200_4B, 40'h0000_1004_13};
	wire logic [27:0] src_cmd = {src[30:19], src[17:11], src[9:2], src[1]};

	pic_src_model i_pic_src_model (.sys_clk, .src_cmd, .wr_timeout_irq, .ext_int, .periph_irq);
	pic_irq_ctrl_unit i_pic_irq_ctrl_unit (.sys_clk, .rst_n, .avs_address, .avs_read,
		.avs_write, .avs_byteenable, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.wr_timeout_irq, .ext_int, .periph_irq, .cpu_irq, .cpu_cause, .cpu_level, .flag_irq_out);

	always #5 sys_clk = ~sys_clk;

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One Avalon access; it completes at the rising edge where waitrequest is sampled low.
	task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest && n < 20);
		if (n >= 20) fails++;
		d = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask
	task automatic settle;
		repeat (8) @(posedge sys_clk);
	endtask
	task automatic put(input logic [31:0] s);
		@(posedge sys_clk);
		src <= s;
		settle();
	endtask

	initial begin
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b1, PIC_MODE_LO_OFS, 32'h5555_5555);
		bus(1'b1, PIC_MODE_HI_OFS, 32'h5555_5555);
		for (int k = 0; k < 8; k++) bus(1'b1, PIC_LEVEL_BASE_OFS + 16'(4 * k), lv[k]);
		bus(1'b1, PIC_MASK_OFS, 32'h2);
		bus(1'b1, PIC_DET_EN_OFS, 32'h1);
		foreach (rows[i]) begin
			put(rows[i][39:8]);
			st = 32'({cpu_irq, cpu_cause, cpu_level});
			e = rows[i][7:0];
			chk(st, 32'({e != 8'h0, e}));
			bus(1'b0, PIC_PENDING_OFS, 32'h0);
			chk(d, rows[i][39:8]);
		end
		put(32'h0000_1000);
		put(32'h0000_1004);
		chk(32'(cpu_cause), 32'hC);
		put(32'h0000_1006);
		chk(32'(cpu_cause), 32'h1);
		bus(1'b1, PIC_LEVEL_BASE_OFS, 32'h0303_0103);
		settle();
		chk(32'({cpu_cause, cpu_level}), 32'h13);
		bus(1'b0, PIC_STATUS_OFS, 32'h0);
		chk(d, 32'h0001_0302);
		put(32'h0000_4000);
		bus(1'b1, PIC_MODE_LO_OFS, 32'h8D55_5555);
		put(32'h0000_6000);
		put(32'h0000_C000);
		put(32'h0000_4000);
		bus(1'b0, PIC_PENDING_OFS, 32'h0);
		chk(d, 32'h0000_A000);
		bus(1'b1, PIC_EDGE_CLR_OFS, 32'h008F_008D);
		settle();
		bus(1'b0, PIC_PENDING_OFS, 32'h0);
		chk(d, 32'h0);
		put(32'h0);
		bus(1'b0, PIC_PENDING_OFS, 32'h0);
		chk(d, 32'h0000_4000);
		chk(32'(cpu_irq), 32'h1);
		bus(1'b1, PIC_MODE_LO_OFS, 32'h8D55_55D5);
		put(32'h0000_0008);
		put(32'h0);
		bus(1'b0, PIC_PENDING_OFS, 32'h0);
		chk(d, 32'h0000_4008);
		chk(32'(cpu_cause), 32'hE);
		bus(1'b1, PIC_DET_EN_OFS, 32'h0);
		settle();
		chk(32'(cpu_irq), 32'h0);
		bus(1'b1, PIC_FLAG0_OFS, 32'h0000_0100);
		settle();
		chk(32'(flag_irq_out), 32'h1);
		bus(1'b1, PIC_FLAG1_OFS, 32'h1);
		bus(1'b0, PIC_FLAG0_OFS, 32'h0);
		chk(d, 32'h0000_0101);
		@(posedge sys_clk);
		rst_n <= 1'b0;
		@(posedge sys_clk);
		rst_n <= 1'b1;
		bus(1'b0, PIC_FLAG0_OFS, 32'h0);
		chk(d, 32'h0);
		chk(32'({cpu_irq, flag_irq_out}), 32'h0);
		wrap_up();
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		fails++;
		wrap_up();
	end
endmodule
